/* hw/crsf_top.v */
/*
  card response and status framer: builds the 48-bit and 136-bit
  responses, shifts them out on the command line, holds data line 0
  busy, keeps the card status word; registers over axi4-lite.
  assumes: CLK much faster than the card clock pin, which is
  sampled here; response requests come from card logic on CLK.
*/
// What this block does
// R1 - shift each response out msb first
// R2 - start bit zero, then direction bit zero
// R3 - crc7 on all but operating-conditions response
// R4 - end every response with a one
// R5 - normal response: index, status, crc, 48 bits
// R6 - busy response same format, may hold dat0
// R7 - 136-bit response: ones, register 127..1, end
// R8 - identity for 2/10, specific data for 9
// R9 - operating response: ones, register, ones
// R10 - register drives busy low, windows low; code clears only bit 31 and keeps the windows
// R11 - no fourth or fifth response format
// R12 - error bits clear after reporting response sent
// R13 - status bits follow state, never steer execution
// R14 - interpretation error: report now, no execution
// R15 - execution error: report in next response
// R16 - operation exceptions reported in later status
// R17 - clear classes: state, next command, read
// R18 - bit 31 addr_range_fault
// R19 - bit 30 address misaligned
// R20 - bit 29 block length illegal
// R21 - bit 28 erase order wrong
// R22 - bit 23 command checksum failed
// R23 - bit 22 command illegal in state
// R24 - crc7 over start bit to payload
`include "crsf_defs.vh"

module crsf_top #(
  parameter AW = 6
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  // axi4-lite slave
  input  wire [AW-1:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [AW-1:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // card clock pin
  input  wire        LINK_CLK,
  // command line and data line 0
  output reg         CMD_O,
  output reg         CMD_OE,
  output reg         DAT0_O,
  output reg         DAT0_OE,
  // response request from card logic
  input  wire        RSP_START,
  output wire        RSP_READY,
  input  wire [1:0]  RSP_KIND,
  input  wire [5:0]  RSP_INDEX,
  input  wire [31:0] RSP_RFAULT,
  output reg         EXEC_GO,
  output reg         RSP_DONE,
  // status sources from card logic
  input  wire [31:0] FAULT_SET,
  input  wire [31:0] STATE_BITS,
  input  wire        CMD_OK,
  input  wire        BUSY_REQ
);

  localparam ST_IDLE = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam ST_BUSY = 2'd2;

  reg  [1:0]   state;
  reg  [1:0]   kind;
  reg  [7:0]   cnt;
  reg  [7:0]   len;
  reg  [135:0] sreg;
  reg  [6:0]   crc;
  reg  [31:0]  sticky;
  reg  [31:0]  sent;
  reg  [31:0]  reported;
  reg  [31:0]  ctrl;
  reg  [31:0]  opcond;
  reg  [31:0]  words [0:7];
  reg  [5:0]   last_index;
  reg          lk_s1;
  reg          lk_s2;
  reg          lk_s3;
  reg          aw_held;
  reg          w_held;
  reg  [AW-1:0] aw_addr;
  reg  [31:0]  w_data;
  reg  [3:0]   w_strb;

  wire         lk_fall;
  wire         crc_win;
  wire         cur_bit;
  wire         fin;
  wire [31:0]  status_word;
  wire [31:0]  opcond_sent;
  wire [127:0] reg_val;
  wire         use_spec;
  wire         wr_go;
  wire [AW-1:0] w_word;
  wire         w_ident;
  wire [2:0]   w_idx;
  wire         w_hit;
  wire [2:0]   r_idx;
  wire         r_ident;
  reg  [31:0]  next_sticky;
  reg  [31:0]  next_rdata;
  reg          next_rok;

  integer i;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[8*k +: 8] = dat[8*k +: 8];
        end
      end
    end
  endfunction

  // card clock pin: two-stage sync, third stage for edge
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lk_s1 <= 1'b1;
      lk_s2 <= 1'b1;
      lk_s3 <= 1'b1;
    end else begin
      lk_s1 <= LINK_CLK;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
    end
  end

  assign lk_fall = lk_s3 & ~lk_s2;

  // status word seen by software and by responses
  assign status_word = sticky | (STATE_BITS & ~`CRSF_ERR_MASK); // R13 R17

  // ready level bit is low while not ready; voltage window bits pass unchanged
  assign opcond_sent = ctrl[0] ? opcond :
                       (opcond & ~(32'h1 << `CRSF_OCR_READY)); // R10

  assign use_spec = (RSP_INDEX == `CRSF_IDX_SPEC); // R8
  assign reg_val  = use_spec ? {words[7], words[6], words[5], words[4]}
                             : {words[3], words[2], words[1], words[0]};

  assign RSP_READY = (state == ST_IDLE);

  // crc field of the normal and busy responses
  assign crc_win = ((kind == `CRSF_K_NORMAL) || (kind == `CRSF_K_BUSY)) &&
                   (cnt >= `CRSF_CRC_FIRST) && (cnt <= `CRSF_CRC_LAST); // R3
  assign cur_bit = crc_win ? crc[6] : sreg[135]; // R1
  assign fin     = (cnt == len);

  // sticky error bits: set wins over every clear
  always @* begin
    next_sticky = sticky;
    if (state == ST_SEND && lk_fall && fin) begin
      next_sticky = next_sticky & ~(sent & `CRSF_CLASS_C_MASK); // R12 R17
    end
    if (CMD_OK) begin
      next_sticky = next_sticky & ~(reported & `CRSF_CLASS_B_MASK); // R17 R22 R23
    end
    next_sticky = next_sticky | (FAULT_SET & `CRSF_ERR_MASK); // R15 R16 R18 R19 R20 R21
    if (RSP_START && state == ST_IDLE) begin
      next_sticky = next_sticky | (RSP_RFAULT & `CRSF_ERR_MASK); // R14
    end
  end

  // response framer
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state      <= ST_IDLE;
      kind       <= `CRSF_K_NORMAL;
      cnt        <= 8'd0;
      len        <= `CRSF_LEN_SHORT;
      sreg       <= 136'h0;
      crc        <= 7'h00;
      sticky     <= 32'h0;
      sent       <= 32'h0;
      reported   <= 32'h0;
      last_index <= 6'h00;
      CMD_O      <= 1'b1;
      CMD_OE     <= 1'b0;
      DAT0_O     <= 1'b1;
      DAT0_OE    <= 1'b0;
      EXEC_GO    <= 1'b0;
      RSP_DONE   <= 1'b0;
    end else begin
      sticky   <= next_sticky;
      EXEC_GO  <= 1'b0;
      RSP_DONE <= 1'b0;
      if (CMD_OK) begin
        reported <= reported & ~`CRSF_CLASS_B_MASK;
      end
      case (state)
        ST_IDLE: begin
          if (RSP_START) begin
            kind       <= RSP_KIND;
            last_index <= RSP_INDEX;
            cnt        <= 8'd0;
            crc        <= 7'h00;
            if (RSP_KIND == `CRSF_K_OPCOND || RSP_KIND == `CRSF_K_REG) begin
              sent <= 32'h0; // R12
            end else begin
              sent <= status_word | (RSP_RFAULT & `CRSF_ERR_MASK); // R12
            end
            EXEC_GO    <= ~|(RSP_RFAULT & `CRSF_ERR_MASK); // R14 R13
            state      <= ST_SEND;
            case (RSP_KIND) // R11
              `CRSF_K_OPCOND: begin
                len  <= `CRSF_LEN_SHORT;
                sreg <= {`CRSF_START_BIT, `CRSF_DIR_BIT, `CRSF_CHK6,
                         opcond_sent, `CRSF_CHK7, `CRSF_END_BIT,
                         88'h0}; // R9
              end
              `CRSF_K_REG: begin
                len  <= `CRSF_LEN_LONG;
                sreg <= {`CRSF_START_BIT, `CRSF_DIR_BIT, `CRSF_CHK6,
                         reg_val[127:1], `CRSF_END_BIT}; // R7 R8
              end
              default: begin
                len  <= `CRSF_LEN_SHORT;
                sreg <= {`CRSF_START_BIT, `CRSF_DIR_BIT, RSP_INDEX,
                         status_word | (RSP_RFAULT & `CRSF_ERR_MASK),
                         7'h00, `CRSF_END_BIT, 88'h0}; // R2 R5 R6
              end
            endcase
          end
        end
        ST_SEND: begin
          if (lk_fall) begin
            if (fin) begin
              CMD_OE   <= 1'b0;
              CMD_O    <= 1'b1;
              RSP_DONE <= 1'b1;
              reported <= sent & `CRSF_CLASS_B_MASK;
              if (kind == `CRSF_K_BUSY && BUSY_REQ) begin
                DAT0_O  <= 1'b0; // R6
                DAT0_OE <= 1'b1;
                state   <= ST_BUSY;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              CMD_OE <= 1'b1;
              CMD_O  <= cur_bit; // R1 R4
              sreg   <= {sreg[134:0], 1'b0};
              cnt    <= cnt + 8'd1;
              if (crc_win) begin
                crc <= {crc[5:0], 1'b0};
              end else if (cnt < `CRSF_CRC_FIRST) begin
                crc <= {crc[5:0], 1'b0} ^
                       ((sreg[135] ^ crc[6]) ? `CRSF_CRC_POLY : 7'h00); // R24
              end
            end
          end
        end
        ST_BUSY: begin
          if (!BUSY_REQ) begin
            DAT0_O  <= 1'b1;
            DAT0_OE <= 1'b0;
            state   <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // axi4-lite write path
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;
  assign wr_go         = aw_held & w_held & ~S_AXI_BVALID;
  assign w_word        = aw_addr - `CRSF_A_IDENT0;
  assign w_idx         = w_word[4:2];
  assign w_ident       = (aw_addr >= `CRSF_A_IDENT0) &&
                         (aw_addr <= `CRSF_A_SPEC3) && (aw_addr[1:0] == 2'b00);
  assign w_hit         = w_ident || (aw_addr == `CRSF_A_CTRL) ||
                         (aw_addr == `CRSF_A_OPCOND);

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= {AW{1'b0}};
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `CRSF_RESP_OKAY;
      ctrl         <= `CRSF_CTRL_RST;
      opcond       <= `CRSF_OPCOND_RST;
      for (i = 0; i < 8; i = i + 1) begin
        words[i] <= `CRSF_WORD_RST;
      end
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= w_hit ? `CRSF_RESP_OKAY : `CRSF_RESP_SLVERR;
        if (aw_addr == `CRSF_A_CTRL) begin
          ctrl <= merge(ctrl, w_data, w_strb) & 32'h1;
        end
        if (aw_addr == `CRSF_A_OPCOND) begin
          opcond <= merge(opcond, w_data, w_strb);
        end
        if (w_ident) begin
          words[w_idx] <= merge(words[w_idx], w_data, w_strb);
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // axi4-lite read path; reads do not disturb status
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign r_ident = (S_AXI_ARADDR >= `CRSF_A_IDENT0) &&
                   (S_AXI_ARADDR <= `CRSF_A_SPEC3) &&
                   (S_AXI_ARADDR[1:0] == 2'b00);
  assign r_idx   = S_AXI_ARADDR[4:2] - 3'd3;

  always @* begin
    next_rdata = 32'h0;
    next_rok   = 1'b1;
    if (r_ident) begin
      next_rdata = words[r_idx];
    end else begin
      case (S_AXI_ARADDR)
        `CRSF_A_CTRL:   next_rdata = ctrl;
        `CRSF_A_STATUS: next_rdata = status_word;
        `CRSF_A_OPCOND: next_rdata = opcond;
        `CRSF_A_LINK:   next_rdata = {24'h0, last_index, DAT0_OE,
                                      ~RSP_READY};
        default:        next_rok   = 1'b0;
      endcase
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= `CRSF_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= next_rdata;
        S_AXI_RRESP  <= next_rok ? `CRSF_RESP_OKAY : `CRSF_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

/* hw/crsf_defs.vh */
/*
  constants of the card response and status framer: frame layout,
  response kinds, status bit positions, register offsets, reset values.
  assumes inclusion by crsf_top.v only.
*/
`ifndef CRSF_DEFS_VH
`define CRSF_DEFS_VH

// frame fields
`define CRSF_START_BIT    1'b0
`define CRSF_DIR_BIT      1'b0
`define CRSF_END_BIT      1'b1
`define CRSF_CHK6         6'h3f
`define CRSF_CHK7         7'h7f
`define CRSF_LEN_SHORT    8'd48
`define CRSF_LEN_LONG     8'd136
`define CRSF_CRC_FIRST    8'd40
`define CRSF_CRC_LAST     8'd46
`define CRSF_CRC_POLY     7'h09
`define CRSF_IDX_SPEC     6'h09

// response kinds
`define CRSF_K_NORMAL     2'd0
`define CRSF_K_BUSY       2'd1
`define CRSF_K_OPCOND     2'd2
`define CRSF_K_REG        2'd3

// status bit positions
`define CRSF_B_ADDR_RANGE 31
`define CRSF_B_ADDR_ALIGN 30
`define CRSF_B_BLK_LEN    29
`define CRSF_B_ERASE_ORD  28
`define CRSF_B_CMD_CSUM   23
`define CRSF_B_ILLEGAL    22
`define CRSF_CLASS_C_MASK 32'hf0000000
`define CRSF_CLASS_B_MASK 32'h00c00000
`define CRSF_ERR_MASK     32'hf0c00000

// operating conditions bit carrying the ready level
`define CRSF_OCR_READY    31

// register offsets
`define CRSF_A_CTRL       6'h00
`define CRSF_A_STATUS     6'h04
`define CRSF_A_OPCOND     6'h08
`define CRSF_A_IDENT0     6'h0c
`define CRSF_A_SPEC3      6'h28
`define CRSF_A_LINK       6'h2c

// reset values
`define CRSF_CTRL_RST     32'h00000000
`define CRSF_OPCOND_RST   32'h00ff8000
`define CRSF_WORD_RST     32'h00000000

// bus responses
`define CRSF_RESP_OKAY    2'b00
`define CRSF_RESP_SLVERR  2'b10

`endif

/* tb/crsf_host.sv */
/*
  link partner: a host that clocks the card and captures its response.
  assumes the bench raises run for one frame and drops it after done.
*/
module crsf_host (
  // control
  input  wire          run,
  // link
  output logic         link_clk,
  input  wire          cmd_o,
  input  wire          cmd_oe,
  // captured frame
  output logic [135:0] frame,
  output logic [7:0]   nbits
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock runs only inside a frame and parks high
  initial begin
    link_clk = 1'b1;
    forever begin
      #80;
      if (run || !link_clk) link_clk = ~link_clk;
    end
  end
  always @(posedge run) begin
    frame = 0;
    nbits = 0;
  end
  // first bit ends up on top
  always @(posedge link_clk) begin
    if (cmd_oe === 1'b1) begin
      frame = {frame[134:0], cmd_o};
      nbits = nbits + 8'd1;
    end
  end
endmodule

/* tb/crsf_assertions.sv */
/*
  port checker of crsf_top: framing, go pulse, busy hold.
  assumes a bind to crsf_top, one clock domain.
*/
module crsf_checker (
  // clock and reset
  input wire        CLK,
  input wire        RST_N,
  // request
  input wire        RSP_START,
  input wire        RSP_READY,
  input wire [31:0] RSP_RFAULT,
  input wire        EXEC_GO,
  input wire        RSP_DONE,
  input wire        BUSY_REQ,
  // lines
  input wire        CMD_O,
  input wire        CMD_OE,
  input wire        DAT0_O,
  input wire        DAT0_OE
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  wire take = RSP_START && RSP_READY;
  wire bad  = |(RSP_RFAULT & 32'hf0c00000);
  a_idle_high: assert property (!CMD_OE |-> CMD_O)
    else $error("line low while idle");
  a_one_frame: assert property (CMD_OE |-> !RSP_READY)
    else $error("ready during frame");
  a_start_low: assert property ($rose(CMD_OE) |-> !CMD_O)
    else $error("start bit high");
  a_end_high: assert property ($fell(CMD_OE) |-> $past(CMD_O))
    else $error("end bit low");
  a_done_end: assert property (RSP_DONE |-> $fell(CMD_OE))
    else $error("done off frame end");
  a_go_clean: assert property (take && !bad |=> EXEC_GO ##1 !EXEC_GO)
    else $error("go missing");
  a_go_block: assert property (take && bad |=> !EXEC_GO)
    else $error("go despite fault");
  a_busy_low: assert property (DAT0_OE |-> !DAT0_O)
    else $error("busy not low");
  a_busy_end: assert property (DAT0_OE && !BUSY_REQ |=> !DAT0_OE)
    else $error("busy held");
endmodule
bind crsf_top crsf_checker u_chk (.CLK(CLK), .RST_N(RST_N), .RSP_START(RSP_START),
  .RSP_READY(RSP_READY), .RSP_RFAULT(RSP_RFAULT), .EXEC_GO(EXEC_GO), .RSP_DONE(RSP_DONE),
  .BUSY_REQ(BUSY_REQ), .CMD_O(CMD_O), .CMD_OE(CMD_OE), .DAT0_O(DAT0_O), .DAT0_OE(DAT0_OE));

/* tb/crsf_top_tb.sv */
/*
  bench of crsf_top: bus, four response kinds, status clearing, busy.
  assumes crsf_host on the link and crsf_checker bound in.
*/
module crsf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] ID = 128'h0123456789abcdef_fedcba9876543211;
  localparam logic [127:0] SP = ~ID;
  localparam logic [31:0]  ST = 32'h00000900;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic        rsp_start = 0, cmd_ok = 0, busy_req = 0, run = 0;
  logic [5:0]  awaddr = 0, araddr = 0, rsp_index = 0;
  logic [1:0]  rsp_kind = 0;
  logic [31:0] wdata = 0, rsp_rfault = 0, fault_set = 0, state_bits = ST;
  int          err_count = 0, compares = 0, cyc = 0;
  wire         awready, wready, bvalid, arready, rvalid, rsp_ready, exec_go;
  wire         rsp_done, cmd_o, cmd_oe, dat0_o, dat0_oe, link_clk;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [135:0] frame;
  wire [7:0]   nbits;
  crsf_top dut (.CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
    .LINK_CLK(link_clk), .CMD_O(cmd_o), .CMD_OE(cmd_oe), .DAT0_O(dat0_o), .DAT0_OE(dat0_oe),
    .RSP_START(rsp_start), .RSP_READY(rsp_ready), .RSP_KIND(rsp_kind),
    .RSP_INDEX(rsp_index), .RSP_RFAULT(rsp_rfault), .EXEC_GO(exec_go), .RSP_DONE(rsp_done),
    .FAULT_SET(fault_set), .STATE_BITS(state_bits), .CMD_OK(cmd_ok), .BUSY_REQ(busy_req));
  crsf_host host (.run(run), .link_clk(link_clk), .cmd_o(cmd_o), .cmd_oe(cmd_oe),
    .frame(frame), .nbits(nbits));
  initial begin
    forever #5 clk = ~clk;
  end
  task summarize;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  task chk(input logic [143:0] g, input logic [143:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wrc(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 0;
      if (wready && wvalid) wvalid <= 0;
    end while (bvalid !== 1'b1);
    chk(bresp, e);
  endtask
  task rdc(input logic [5:0] a, input logic [33:0] e);
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 0;
    end while (rvalid !== 1'b1);
    chk({rresp, rdata}, e);
  endtask
  // normal frame with its checksum
  function automatic logic [135:0] nf(input logic [5:0] i, input logic [31:0] s);
    logic [39:0] m;
    logic [6:0]  c;
    m = {2'b00, i, s};
    c = 0;
    for (int b = 39; b >= 0; b--) c = {c[5:0], 1'b0} ^ ((c[6] ^ m[b]) ? 7'h09 : 7'h00);
    return {88'h0, m, c, 1'b1};
  endfunction
  task rsp(input logic [1:0] k, input logic [5:0] i, input logic [31:0] f,
           input logic [135:0] e, input logic [7:0] n);
    rsp_kind <= k;
    rsp_index <= i;
    rsp_rfault <= f;
    rsp_start <= 1;
    @(posedge clk);
    rsp_start <= 0;
    @(posedge clk);
    chk(exec_go, (f & 32'hf0c00000) == 0);
    run <= 1;
    while (rsp_done !== 1'b1) @(posedge clk);
    run <= 0;
    chk({nbits, frame}, {n, e});
  endtask
  task t_regs;
    logic [5:0] i;
    rdc(6'h00, 34'h0);
    rdc(6'h08, 34'h000ff8000);
    wrc(6'h30, 32'h1, 2'b10);
    rdc(6'h30, 34'h200000000);
    for (i = 0; i < 4; i++) begin
      wrc(6'h0c + (i << 2), ID[32*i +: 32], 2'b00);
      wrc(6'h1c + (i << 2), SP[32*i +: 32], 2'b00);
    end
    rdc(6'h24, {2'b00, SP[95:64]});
  endtask
  task t_stat;
    fault_set <= 32'hd0000000;
    @(posedge clk);
    fault_set <= 0;
    rdc(6'h04, 34'h0d0000900);
    rsp(2'd0, 6'd13, 0, nf(6'd13, 32'hd0000900), 48);
    rdc(6'h04, {2'b00, ST});
    rsp(2'd0, 6'd16, 32'h20c00000, nf(6'd16, 32'h20c00900), 48);
    rdc(6'h04, 34'h000c00900);
    cmd_ok <= 1;
    @(posedge clk);
    cmd_ok <= 0;
    rdc(6'h04, {2'b00, ST});
    state_bits <= 32'h80000200;
    rdc(6'h04, 34'h000000200);
    state_bits <= ST;
  endtask
  task t_ocr;
    logic [1:0] c;
    fault_set <= 32'h10000000;
    @(posedge clk);
    fault_set <= 0;
    wrc(6'h08, 32'h80ff8000, 2'b00);
    for (c = 0; c < 2; c++) begin
      wrc(6'h00, {31'h0, c[0]}, 2'b00);
      rsp(2'd2, 6'd1, 0, {88'h0, 8'h3f, c[0], 31'h00ff8000, 8'hff}, 48);
    end
    rdc(6'h04, 34'h010000900);
  endtask
  task t_long;
    logic [5:0]   x [3];
    logic [127:0] g;
    x = '{6'd2, 6'd10, 6'd9};
    for (int n = 0; n < 3; n++) begin
      g = (x[n] == 6'd9) ? SP : ID;
      rsp(2'd3, x[n], 0, {8'h3f, g[127:1], 1'b1}, 136);
    end
  endtask
  task t_busy;
    busy_req <= 1;
    rsp(2'd1, 6'd7, 0, nf(6'd7, 32'h10000900), 48);
    repeat (2) @(posedge clk);
    chk({dat0_oe, dat0_o}, 2'b10);
    rdc(6'h2c, 34'h00000001f);
    rdc(6'h04, {2'b00, ST});
    busy_req <= 0;
    repeat (2) @(posedge clk);
    chk({dat0_oe, dat0_o}, 2'b01);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs();
    t_stat();
    t_ocr();
    t_long();
    t_busy();
    summarize();
  end
endmodule
